// ==== rtl/half_bridge_spi_control.sv ====
// serial control and diagnostic logic of a six-channel half-bridge driver
// assumes: shiftClk stands still while selectLowPin is high; sense levels,
// select and the serial input come from pins and are asynchronous to mclk
//
// Summary of operation
// - one 16-bit word per frame
// - least significant bit first both directions
// - select rising moves word into control register
// - serial output driven only while select low
// - status shifts out while command shifts in
// - bits pass through to next chained device
// - bit 15 enables overvoltage shutdown
// - bit 14 enables underload shutdown
// - bit 13 enables overcurrent shutdown
// - bits 12..1 switch high and low outputs
// - bit 0 set clears latched status
// - status 15 reports over or under voltage
// - status 14 reports any underload fault
// - status 13 reports any overload fault
// - status 12..1 output states, 0 thermal
// - sleep input low loses all settings
// - power-up reset leaves all outputs off
// - commands ignored while logic supply low
// - outputs stay on until supply, command, fault
// - overcurrent enabled shuts output; not while off
// - load fault shutoffs and flags latch until clear
// - select falling shows thermal warning at once
`default_nettype none
`include "half_bridge_cfg.svh"
module half_bridge_spi_control (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      shiftClk,
  input  wire logic                      selectLowPin,
  input  wire logic                      serialIn,
  output logic                           serialOut,
  output logic                           serialOutOe,
  input  wire half_bridge_pkg::sense_t   sense,
  output logic [`CHAN_N-1:0]             driveOn,
  output logic [`WORD_W-1:0]             statusWord
);

  // ---------------------------------------------------------------
  // link side, clocked by the host's shift clock
  // ---------------------------------------------------------------
  logic [`WORD_W-1:0] rxShift_q;
  logic [`CNT_W-1:0]  rxCnt_q;
  logic [`CNT_W-1:0]  rxCnt_d;
  logic               fresh_q;
  logic [`CNT_W-1:0]  txPtr_q;
  logic [`CNT_W-1:0]  txPtr_d;
  logic               spill_q;
  logic               framing;
  logic               txFromStatus;
  logic [`WORD_W-1:0] statusHold_q;

  assign framing = ~selectLowPin;

  // fresh marks the first shift edge of a frame; set while select is high
  always_ff @(posedge shiftClk or posedge selectLowPin) begin
    if (selectLowPin) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // counter saturates so that an over-long frame never looks like 16 bits
  assign rxCnt_d = fresh_q ? 5'h01 :
                   (rxCnt_q == `CNT_MAX) ? rxCnt_q :
                   rxCnt_q + 5'h01;

  // data shifts in at the msb so the first bit ends at bit 0
  always_ff @(posedge shiftClk) begin
    if (framing) begin
      rxShift_q <= {serialIn, rxShift_q[`WORD_W-1:1]};
      rxCnt_q   <= rxCnt_d;
    end
  end

  assign txPtr_d = (txPtr_q == `CNT_MAX) ? txPtr_q : txPtr_q + 5'h01;

  // output side advances on the falling edge, half a period of setup
  always_ff @(negedge shiftClk or posedge selectLowPin) begin
    if (selectLowPin) begin
      txPtr_q <= 5'h00;
      spill_q <= 1'b0;
    end else begin
      txPtr_q <= txPtr_d;
      spill_q <= rxShift_q[0];
    end
  end

  // status bits first, then the bits received sixteen clocks earlier
  assign txFromStatus = (txPtr_q < `FRAME_BITS);
  // before any shift clock the pointer is zero: thermal warning shows
  assign serialOut = txFromStatus ? statusHold_q[txPtr_q[3:0]]
                                  : spill_q;
  assign serialOutOe = framing;

  // ---------------------------------------------------------------
  // core side, clocked by mclk
  // ---------------------------------------------------------------
  half_bridge_pkg::sense_t senseMeta_q;
  half_bridge_pkg::sense_t senseSync_q;
  logic               selMeta_q;
  logic               selSync_q;
  logic               selPrev_q;
  logic               freshMeta_q;
  logic               freshSync_q;
  logic               selFall;
  logic               clocked_q;
  logic               clocked_d;

  always_ff @(posedge mclk) begin
    if (ce) begin
      senseMeta_q <= sense;
      senseSync_q <= senseMeta_q;
      selMeta_q   <= selectLowPin;
      selSync_q   <= selMeta_q;
      selPrev_q   <= selSync_q;
      freshMeta_q <= fresh_q;
      freshSync_q <= freshMeta_q;
    end
  end

  // set beats clear for every latched flag
  function automatic logic [`CHAN_N-1:0] latchNext(
    input logic [`CHAN_N-1:0] setEv,
    input logic [`CHAN_N-1:0] held,
    input logic               clr
  );
    latchNext = setEv | (held & {`CHAN_N{~clr}});
  endfunction

  logic               wipe;
  logic               selRise;
  logic               wordOk;
  logic               commit;
  logic               clearReq;
  logic [`WORD_W-1:0] cmd_q;
  logic [`WORD_W-1:0] cmd_d;
  logic               ovEnable;
  logic               uldEnable;
  logic               ocEnable;
  logic [`CHAN_N-1:0] outCmd;
  logic               supplyEv;
  logic               allOff;

  // sleep drops every setting, exactly like power-up
  assign wipe     = rst | ~senseSync_q.wake;
  assign selRise  = selSync_q & ~selPrev_q;
  assign selFall  = ~selSync_q & selPrev_q;

  // a select pulse with no shift clock leaves the old count standing;
  // without this mark it would replay the previous word and its clear bit
  assign clocked_d = (~selSync_q & ~freshSync_q) | (clocked_q & ~selFall);

  always_ff @(posedge mclk) begin
    if (wipe) begin
      clocked_q <= 1'b0;
    end else if (ce) begin
      clocked_q <= clocked_d;
    end
  end

  // a frame that is not exactly one word is discarded whole
  assign wordOk   = (rxCnt_q == `FRAME_BITS) & clocked_q;
  // the word is stable here: the shift clock stops while select is high
  assign commit   = selRise & wordOk & ~senseSync_q.logicSupplyLow;
  assign clearReq = commit & rxShift_q[`CMD_CLEAR];

  // the clear bit is a strobe and is not kept in the control register
  assign cmd_d = commit ? {rxShift_q[`WORD_W-1:1], 1'b0} : cmd_q;

  always_ff @(posedge mclk) begin
    if (wipe) begin
      cmd_q <= `WORD_RESET;
    end else if (ce) begin
      cmd_q <= cmd_d;
    end
  end

  assign ovEnable  = cmd_q[`CMD_OV_EN];
  assign uldEnable = cmd_q[`CMD_ULD_EN];
  assign ocEnable  = cmd_q[`CMD_OC_EN];
  assign outCmd    = cmd_q[`CMD_OUT_HI:`CMD_OUT_LO];

  // ---------------------------------------------------------------
  // fault latches
  // ---------------------------------------------------------------
  logic [`CHAN_N-1:0] uldOff_q;
  logic [`CHAN_N-1:0] ocOff_q;
  logic [`CHAN_N-1:0] uldOff_d;
  logic [`CHAN_N-1:0] ocOff_d;
  logic [`CHAN_N-1:0] driveOn_q;
  logic [`CHAN_N-1:0] driveOn_d;

  // per channel: enabled shutdown latches the offending output off
  genvar ch;
  generate
    for (ch = 0; ch < `CHAN_N; ch = ch + 1) begin : g_chan
      assign uldOff_d[ch] = (uldEnable & driveOn_q[ch] & senseSync_q.underload[ch])
                          | (uldOff_q[ch] & ~clearReq);
      // with the enable low the output only current-limits in the stage
      assign ocOff_d[ch]  = (ocEnable & driveOn_q[ch] & senseSync_q.overCurrent[ch])
                          | (ocOff_q[ch] & ~clearReq);
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (wipe) begin
      uldOff_q <= `CHAN_RESET;
      ocOff_q  <= `CHAN_RESET;
    end else if (ce) begin
      uldOff_q <= uldOff_d;
      ocOff_q  <= ocOff_d;
    end
  end

  // overvoltage shutdown is not latched: outputs return once it clears
  assign supplyEv = senseSync_q.overVoltage | senseSync_q.underVoltage;
  assign allOff   = (ovEnable & senseSync_q.overVoltage)
                  | senseSync_q.underVoltage
                  | senseSync_q.overTemp;

  assign driveOn_d = outCmd & ~uldOff_q & ~ocOff_q
                   & {`CHAN_N{~allOff}};

  always_ff @(posedge mclk) begin
    if (wipe) begin
      driveOn_q <= `CHAN_RESET;
    end else if (ce) begin
      driveOn_q <= driveOn_d;
    end
  end

  assign driveOn = driveOn_q;

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic [3:0] flag_q;
  logic [3:0] flag_d;
  logic [3:0] flagSet;

  // order: supply, underload, overload, thermal warning
  assign flagSet = {supplyEv,
                    |(senseSync_q.underload & driveOn_q),
                    |senseSync_q.overCurrent,
                    senseSync_q.thermalWarn};

  // the latch function is reused at four bits via its low lanes
  logic [`CHAN_N-1:0] flagWide;
  assign flagWide = latchNext({8'h00, flagSet}, {8'h00, flag_q}, clearReq);
  assign flag_d   = flagWide[3:0];

  always_ff @(posedge mclk) begin
    if (wipe) begin
      flag_q <= 4'h0;
    end else if (ce) begin
      flag_q <= flag_d;
    end
  end

  half_bridge_pkg::status_t statusNow;
  assign statusNow.supplyFail     = flag_q[3] | supplyEv;
  assign statusNow.underloadFault = flag_q[2];
  assign statusNow.overloadFault  = flag_q[1];
  assign statusNow.outState       = driveOn_q;
  assign statusNow.thermalWarn    = flag_q[0];

  // snapshot frozen while selected so the link reads a steady word;
  // select setup far exceeds the two-flop latency, so it settles first
  always_ff @(posedge mclk) begin
    if (wipe) begin
      statusHold_q <= `WORD_RESET;
    end else if (ce & selSync_q) begin
      statusHold_q <= statusNow;
    end
  end

  assign statusWord = statusHold_q;

endmodule
`default_nettype wire

// ==== pkg/half_bridge_cfg.svh ====
// constants for the half-bridge serial control block
// assumes: included by bare name from the package and the design file
`ifndef HALF_BRIDGE_CFG_SVH
`define HALF_BRIDGE_CFG_SVH
`define WORD_W         16
`define CNT_W          5
`define CHAN_N         12
`define FRAME_BITS     5'h10
`define CNT_MAX        5'h11
`define CMD_OV_EN      15
`define CMD_ULD_EN     14
`define CMD_OC_EN      13
`define CMD_OUT_HI     12
`define CMD_OUT_LO     1
`define CMD_CLEAR      0
`define ST_SUPPLY      15
`define ST_UNDERLOAD   14
`define ST_OVERLOAD    13
`define ST_THERMAL     0
`define WORD_RESET     16'h0000
`define CHAN_RESET     12'h000
`endif

// ==== pkg/half_bridge_pkg.sv ====
// types shared by the half-bridge serial control block
// assumes: half_bridge_cfg.svh is on the include path
`default_nettype none
`include "half_bridge_cfg.svh"
package half_bridge_pkg;
  // analogue sense levels; all arrive asynchronously to mclk
  typedef struct packed {
    logic                  wake;
    logic                  logicSupplyLow;
    logic                  overVoltage;
    logic                  underVoltage;
    logic                  thermalWarn;
    logic                  overTemp;
    logic [`CHAN_N-1:0]    overCurrent;
    logic [`CHAN_N-1:0]    underload;
  } sense_t;
  typedef struct packed {
    logic                  supplyFail;
    logic                  underloadFault;
    logic                  overloadFault;
    logic [`CHAN_N-1:0]    outState;
    logic                  thermalWarn;
  } status_t;
endpackage
`default_nettype wire

// ==== bench/half_bridge_spi_control_assertions.sv ====
// concurrent checks on the ports of the half-bridge serial control block
// assumes: bound to the top module; sense stays steady while a frame is open
`default_nettype none
`include "half_bridge_cfg.svh"
module half_bridge_spi_control_assertions (
  input wire logic                    mclk,
  input wire logic                    rst,
  input wire logic                    ce,
  input wire logic                    shiftClk,
  input wire logic                    selectLowPin,
  input wire logic                    serialIn,
  input wire logic                    serialOut,
  input wire logic                    serialOutOe,
  input wire half_bridge_pkg::sense_t sense,
  input wire logic [`CHAN_N-1:0]      driveOn,
  input wire logic [`WORD_W-1:0]      statusWord
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // sync delay on sense is two flops, so six quiet cycles leave the outputs settled
  sequence s_quietFrame; (!selectLowPin && $stable(sense))[*6]; endsequence
  sequence s_idleAwake; (selectLowPin && sense.wake)[*6]; endsequence
  property p_oeOn; !selectLowPin |-> serialOutOe; endproperty
  a_oeOn: assert property (p_oeOn) else $error("serial output not driven");
  property p_oeOff; selectLowPin |-> !serialOutOe; endproperty
  a_oeOff: assert property (p_oeOff) else $error("serial output driven");
  property p_frameHold; s_quietFrame |=> $stable(driveOn); endproperty
  a_frameHold: assert property (p_frameHold) else $error("outputs moved in frame");
  property p_reset; disable iff (1'b0) rst |=> driveOn == '0 && statusWord == '0; endproperty
  a_reset: assert property (p_reset) else $error("reset left state");
  property p_sleep; !sense.wake [*4] |=> driveOn == '0; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep kept outputs");
  property p_thermal; s_idleAwake and sense.thermalWarn [*6] |=> statusWord[`ST_THERMAL];
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal flag missing");
  property p_supply; s_idleAwake and (sense.overVoltage || sense.underVoltage) [*6]
    |=> statusWord[`ST_SUPPLY]; endproperty
  a_supply: assert property (p_supply) else $error("supply flag missing");
  property p_overload; s_idleAwake and (|sense.overCurrent) [*6] |=> statusWord[`ST_OVERLOAD];
  endproperty
  a_overload: assert property (p_overload) else $error("overload flag missing");
  property p_underload; s_idleAwake and (|(sense.underload & driveOn)) [*6]
    |=> statusWord[`ST_UNDERLOAD]; endproperty
  a_underload: assert property (p_underload) else $error("underload flag missing");
endmodule
`default_nettype wire

// ==== bench/spi_host_model.sv ====
// host serial master that frames words for the half-bridge control block
// assumes: one call at a time; serialLine is the resolved status wire
`default_nettype none
module spi_host_model (
  output logic     shiftClk,
  output logic     selectLowPin,
  output logic     serialIn,
  input wire logic serialLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock stands still low between frames; data line is driven low between frames
  // select rises just after time zero so the link pointers see a clean edge
  initial begin
    shiftClk = 1'b0;
    selectLowPin = 1'b0;
    serialIn = 1'b0;
    #1;
    selectLowPin = 1'b1;
  end
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    selectLowPin = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      serialIn = tx[i];
      #40;
      shiftClk = 1'b1;
      rx[i] = serialLine;
      #40;
      shiftClk = 1'b0;
    end
    #40;
    selectLowPin = 1'b1;
    serialIn = 1'b0;
    #200;
  endtask
  task automatic peek(output logic b);
    selectLowPin = 1'b0;
    #100;
    b = serialLine;
    selectLowPin = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_half_bridge_spi_control.sv ====
// self-checking bench for the half-bridge serial control block
// assumes: package, design, checker and host model are compiled first
`default_nettype none
`include "half_bridge_cfg.svh"
module tb_half_bridge_spi_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic shiftClk, selectLowPin, serialIn, serialOut, serialOutOe, b;
  half_bridge_pkg::sense_t s = '{wake: 1'b1, default: '0};
  logic [`CHAN_N-1:0] driveOn;
  logic [`WORD_W-1:0] statusWord;
  logic [31:0] rx;
  int mismatches = 0;
  int compares = 0;
  wire serialLine = serialOutOe ? serialOut : 1'bz;
  always #2.5 mclk = ~mclk;
  half_bridge_spi_control i_half_bridge_spi_control (.mclk, .rst, .ce, .shiftClk,
    .selectLowPin, .serialIn, .serialOut, .serialOutOe, .sense(s), .driveOn, .statusWord);
  spi_host_model i_spi_host_model (.shiftClk, .selectLowPin, .serialIn, .serialLine);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic w10; repeat (10) @(posedge mclk); endtask
  task automatic put(input logic [15:0] w); i_spi_host_model.xfer({16'h0, w}, 16, rx); endtask
  task automatic t_cmd;
    logic [15:0] c [3] = '{16'h0002, 16'h1FFE, 16'h1555};
    logic [15:0] prev = 16'h0000;
    foreach (c[i]) begin
      put(c[i]);
      chk(driveOn, c[i][12:1]);
      chk(rx[12:1], prev[12:1]);
      chk(statusWord[12:1], c[i][12:1]);
      prev = c[i];
    end
    i_spi_host_model.xfer(32'h0000_A5A4, 32, rx);
    chk(rx[31:16], 16'hA5A4);
    chk(driveOn, 12'hAAA);
    $display("command and chain done");
  endtask
  task automatic hit(input int en, input logic [11:0] v);
    @(posedge mclk) begin
      if (en == 13) s.overCurrent <= v;
      else s.underload <= v;
    end
    w10;
  endtask
  task automatic t_fault(input int en);
    put(16'h0004);
    hit(en, 12'h002);
    chk(driveOn, 12'h002);
    chk(statusWord[en], 1'b1);
    hit(en, 12'h000);
    put(16'h0005 | (16'h0001 << en));
    hit(en, 12'h002);
    hit(en, 12'h000);
    chk(driveOn, 12'h000);
    put(16'h0005 | (16'h0001 << en));
    chk(driveOn, 12'h002);
    chk(statusWord[en], 1'b0);
    $display("fault %0d done", en);
  endtask
  task automatic t_supply;
    put(16'h8004);
    @(posedge mclk) s.overVoltage <= 1'b1;
    w10;
    chk(driveOn, 12'h000);
    chk(statusWord[15], 1'b1);
    @(posedge mclk) s.overVoltage <= 1'b0;
    w10;
    chk(driveOn, 12'h002);
    @(posedge mclk) s.overTemp <= 1'b1;
    w10;
    chk(driveOn, 12'h000);
    @(posedge mclk) begin
      s.overTemp <= 1'b0;
      s.underVoltage <= 1'b1;
    end
    w10;
    chk(driveOn, 12'h000);
    @(posedge mclk) s.underVoltage <= 1'b0;
    w10;
    chk(driveOn, 12'h002);
    @(posedge mclk) s.thermalWarn <= 1'b1;
    w10;
    @(posedge mclk) s.thermalWarn <= 1'b0;
    w10;
    i_spi_host_model.peek(b);
    chk(b, 1'b1);
    put(16'h0005);
    chk(statusWord[0], 1'b0);
    @(posedge mclk) s.thermalWarn <= 1'b1;
    w10;
    @(posedge mclk) s.thermalWarn <= 1'b0;
    i_spi_host_model.peek(b);
    chk(statusWord[0], 1'b1);
    @(posedge mclk) s.logicSupplyLow <= 1'b1;
    w10;
    put(16'h1FFE);
    chk(driveOn, 12'h002);
    @(posedge mclk) s <= '{wake: 1'b0, default: '0};
    w10;
    chk(driveOn, 12'h000);
    @(posedge mclk) s.wake <= 1'b1;
    w10;
    chk(driveOn, 12'h000);
    $display("supply and sleep done");
  endtask
  initial begin
    #300us;
    mismatches++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    w10;
    chk(driveOn, 12'h000);
    t_cmd;
    t_fault(13);
    t_fault(14);
    t_supply;
    test_done;
  end
endmodule
bind half_bridge_spi_control half_bridge_spi_control_assertions
  i_half_bridge_spi_control_assertions (.mclk, .rst, .ce, .shiftClk, .selectLowPin,
  .serialIn, .serialOut, .serialOutOe, .sense, .driveOn, .statusWord);
`default_nettype wire
